// *** hw/lpmc_pkg.sv ***
// Package for the low-power mode controller: modes, timing constants
package lpmc_pkg;
  // Modes, one-hot
  typedef enum logic [5:0] {
    LPMC_RUN      = 6'h01,
    LPMC_WAIT     = 6'h02,
    LPMC_LP_RUN   = 6'h04,
    LPMC_LP_WAIT  = 6'h08,
    LPMC_ACT_HALT = 6'h10,
    LPMC_HALT     = 6'h20
  } lpmc_mode_t;

  localparam int  LPMC_CLK_MHZ        = 250;
  // Fast wakeup time in ns
  localparam int  LPMC_FAST_WAKE_NS   = 5000;
  localparam int  LPMC_FAST_WAKE_CYC  = (LPMC_FAST_WAKE_NS * LPMC_CLK_MHZ) / 1000;
  // Reference recovery time in ns, plain default
  localparam int  LPMC_REF_WAKE_NS    = 16000;
  localparam int  LPMC_REF_WAKE_CYC   = (LPMC_REF_WAKE_NS * LPMC_CLK_MHZ) / 1000;
  localparam int  LPMC_CNT_W          = 16;
  localparam int  LPMC_SYNC_STAGES    = 2;
endpackage : lpmc_pkg

// *** hw/lpmc_sync.sv ***
// Two-stage synchroniser for a group of pin-level wakeup inputs
`timescale 1ns/100ps
`default_nettype none
module lpmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // lpmc_sync
`default_nettype wire

// *** hw/lpmc_ctrl.sv ***
// Low-power mode sequencer with clock gating and wakeup source selection
//
// What this block does
// RULE1: In wait mode the CPU clock is off while the selected peripherals keep their clocks.
// RULE2: Wait mode is entered by either wait instruction and left on interrupt, event or reset.
// RULE3: Low power run clocks CPU and peripherals from the slow oscillator, from RAM, flash off.
// RULE4: Low power run is entered only by software request and left only by software or reset.
// RULE5: Interrupts must be masked by software and never cause an exit from the low power modes.
// RULE6: A wait-for-event in low power run enters low power wait, which also stops the CPU clock.
// RULE7: Low power wait wakes on reset or on an internal or external peripheral event.
// RULE8: An event ending low power wait returns to low power run with the CPU clock restarted.
// RULE9: Active-halt keeps only the RTC clock and wakes on RTC interrupt or external interrupt.
// RULE10: Halt stops CPU and peripheral clocks, keeps RAM powered, wakes on external or halt-wake.
// RULE11: The reference may be off in halt, and a fast-wake setting skips its recovery wait.
// RULE12: A non-reset wake from wait, active-halt or halt restores clocks and returns to run.
`timescale 1ns/100ps
`default_nettype none
module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int NUM_PERIPH   = 8,
  parameter int REF_WAKE_CYC = lpmc_pkg::LPMC_REF_WAKE_CYC,
  parameter int FAST_WAKE_CYC = lpmc_pkg::LPMC_FAST_WAKE_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  wait_for_event_instr,
  input  wire logic                  wait_for_interrupt_instr,
  input  wire logic                  halt_req,
  input  wire logic                  halt_rtc_keep,
  input  wire logic                  lp_run_enter_req,
  input  wire logic                  lp_run_exit_req,
  input  wire logic                  slow_osc_sel_ext,
  input  wire logic                  ref_off_in_halt,
  input  wire logic                  fast_wake_en,
  input  wire logic [NUM_PERIPH-1:0] periph_run_sel,
  input  wire logic                  int_irq,
  input  wire logic                  int_event,
  input  wire logic                  rtc_irq,
  input  wire logic                  ext_irq_pin,
  input  wire logic                  ext_event_pin,
  input  wire logic                  halt_wake_periph,
  output var  logic                  cpu_clk_en,
  output var  logic [NUM_PERIPH-1:0] periph_clk_en,
  output var  logic                  rtc_clk_en,
  output var  logic                  flash_on,
  output var  logic                  slow_clk_sel,
  output var  logic                  low_speed_internal_osc_en,
  output var  logic                  low_speed_external_osc_en,
  output var  logic                  reg_ulp,
  output var  logic                  ref_on,
  output var  logic                  wake_pulse,
  output var  logic [5:0]            mode_out
);
  import lpmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs, synchronised
  logic       ext_irq_s;
  logic       ext_event_s;
  logic [1:0] sync_q;

  lpmc_sync #(.WIDTH(2)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({ext_irq_pin, ext_event_pin}),
    .sync_out (sync_q)
  );
  assign ext_irq_s   = sync_q[1];
  assign ext_event_s = sync_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  lpmc_mode_t             mode_reg;
  lpmc_mode_t             mode_next;
  logic                   halt_like;
  logic                   wake_wait;
  logic                   wake_lpw;
  logic                   wake_ah;
  logic                   wake_halt;
  logic                   ref_wait_reg;
  logic [LPMC_CNT_W-1:0]  wake_cnt_reg;

  assign wake_wait = int_irq | int_event | ext_irq_s | ext_event_s;          // RULE2
  assign wake_lpw  = int_event | ext_event_s;                                // RULE7 RULE5
  assign wake_ah   = rtc_irq | ext_irq_s;                                    // RULE9
  assign wake_halt = ext_irq_s | halt_wake_periph;                           // RULE10
  assign halt_like = (mode_reg == LPMC_ACT_HALT) || (mode_reg == LPMC_HALT);

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      LPMC_RUN: begin
        if (lp_run_enter_req) begin
          mode_next = LPMC_LP_RUN;                                           // RULE4
        end else if (halt_req) begin
          mode_next = halt_rtc_keep ? LPMC_ACT_HALT : LPMC_HALT;
        end else if (wait_for_event_instr || wait_for_interrupt_instr) begin
          mode_next = LPMC_WAIT;                                             // RULE2
        end
      end
      LPMC_WAIT: begin
        if (wake_wait) begin
          mode_next = LPMC_RUN;                                              // RULE12
        end
      end
      LPMC_LP_RUN: begin
        if (lp_run_exit_req) begin
          mode_next = LPMC_RUN;                                              // RULE4
        end else if (wait_for_event_instr) begin
          mode_next = LPMC_LP_WAIT;                                          // RULE6
        end
      end
      LPMC_LP_WAIT: begin
        if (wake_lpw) begin
          mode_next = LPMC_LP_RUN;                                           // RULE8
        end
      end
      LPMC_ACT_HALT,
      LPMC_HALT: begin
        // Leave only once the recovery count has run out; one wake is enough
        if (ref_wait_reg && wake_cnt_reg == '0) begin
          mode_next = LPMC_RUN;                                              // RULE11 RULE12
        end
      end
      default: mode_next = LPMC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= LPMC_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference recovery on wake from halt; counter holds the exit
  logic halt_wake_seen;
  assign halt_wake_seen = ((mode_reg == LPMC_ACT_HALT) && wake_ah) ||
                          ((mode_reg == LPMC_HALT) && wake_halt);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_wait_reg <= 1'b0;
      wake_cnt_reg <= '0;
    end else if (!halt_like) begin
      ref_wait_reg <= 1'b0;
      wake_cnt_reg <= '0;
    end else if (halt_wake_seen && !ref_wait_reg && wake_cnt_reg == '0) begin
      // Fast wake skips the reference settling, RULE11
      ref_wait_reg <= 1'b1;
      wake_cnt_reg <= (ref_off_in_halt && !fast_wake_en) ?
                      LPMC_CNT_W'(REF_WAKE_CYC - 1) : LPMC_CNT_W'(FAST_WAKE_CYC - 1); // RULE11
    end else if (ref_wait_reg) begin
      if (wake_cnt_reg == '0) begin
        ref_wait_reg <= 1'b0;
      end else begin
        wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock gating and power controls, all registered from next mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= '1;
      rtc_clk_en    <= 1'b1;
    end else begin
      cpu_clk_en    <= (mode_next == LPMC_RUN) || (mode_next == LPMC_LP_RUN); // RULE1 RULE6 RULE8
      rtc_clk_en    <= (mode_next != LPMC_HALT);                              // RULE9
      unique case (mode_next)
        LPMC_RUN:      periph_clk_en <= '1;                                   // RULE12
        LPMC_WAIT,
        LPMC_LP_RUN,
        LPMC_LP_WAIT:  periph_clk_en <= periph_run_sel;                       // RULE1 RULE3
        default:       periph_clk_en <= '0;                                   // RULE9 RULE10
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_on                  <= 1'b1;
      slow_clk_sel              <= 1'b0;
      low_speed_internal_osc_en <= 1'b0;
      low_speed_external_osc_en <= 1'b0;
      reg_ulp                   <= 1'b0;
      ref_on                    <= 1'b1;
      mode_out                  <= 6'h01;
    end else begin
      // Low power run and wait share the slow clock and flash-off setup
      flash_on     <= !((mode_next == LPMC_LP_RUN) || (mode_next == LPMC_LP_WAIT)); // RULE3
      slow_clk_sel <= (mode_next == LPMC_LP_RUN) || (mode_next == LPMC_LP_WAIT);    // RULE3
      reg_ulp      <= (mode_next == LPMC_LP_RUN) || (mode_next == LPMC_LP_WAIT);    // RULE3
      low_speed_internal_osc_en <= ((mode_next == LPMC_LP_RUN) ||
                                    (mode_next == LPMC_LP_WAIT)) && !slow_osc_sel_ext;
      low_speed_external_osc_en <= ((mode_next == LPMC_LP_RUN) ||
                                    (mode_next == LPMC_LP_WAIT)) && slow_osc_sel_ext;
      // Reference comes back as soon as a wake is seen
      ref_on   <= !(((mode_next == LPMC_HALT) || (mode_next == LPMC_ACT_HALT)) &&
                    ref_off_in_halt && !halt_wake_seen && !ref_wait_reg);   // RULE11
      mode_out <= mode_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= (mode_reg != mode_next) &&
                    ((mode_next == LPMC_RUN && mode_reg != LPMC_LP_RUN) ||
                     mode_next == LPMC_LP_RUN && mode_reg == LPMC_LP_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles spent in recovery; bounds the fast wake without a long delay range
  logic [LPMC_CNT_W-1:0] rec_cyc_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_cyc_reg <= '0;
    end else if (ref_wait_reg) begin
      rec_cyc_reg <= rec_cyc_reg + 1'b1;
    end else begin
      rec_cyc_reg <= '0;
    end
  end

  AST_WAIT_CPU_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    (mode_reg == LPMC_WAIT) |-> !cpu_clk_en) else $error("cpu clock on in wait");
  AST_WAIT_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
    (mode_reg == LPMC_WAIT && int_irq) |=> (mode_reg == LPMC_RUN && cpu_clk_en))
    else $error("wait not left on interrupt");
  AST_LPRUN_SETUP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
    (mode_reg == LPMC_LP_RUN) |-> (!flash_on && reg_ulp && slow_clk_sel && cpu_clk_en))
    else $error("low power run setup wrong");
  AST_LPRUN_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
    (mode_reg != LPMC_LP_RUN && mode_reg != LPMC_LP_WAIT && mode_next == LPMC_LP_RUN)
      |-> lp_run_enter_req) else $error("low power run entered without request");
  AST_NO_IRQ_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5 RULE7
    (mode_reg == LPMC_LP_WAIT && !int_event && !ext_event_s) |=> (mode_reg == LPMC_LP_WAIT))
    else $error("low power wait left without event");
  AST_LPWAIT_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
    (mode_reg == LPMC_LP_RUN && !lp_run_exit_req && wait_for_event_instr)
      |=> (mode_reg == LPMC_LP_WAIT && !cpu_clk_en && !flash_on))
    else $error("low power wait not entered");
  AST_LPWAIT_BACK: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
    (mode_reg == LPMC_LP_WAIT && int_event) |=> (mode_reg == LPMC_LP_RUN && cpu_clk_en))
    else $error("event did not restore low power run");
  AST_AHALT_CLKS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
    (mode_reg == LPMC_ACT_HALT) |-> (rtc_clk_en && !cpu_clk_en && periph_clk_en == '0))
    else $error("active-halt clock gating wrong");
  AST_HALT_CLKS: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
    (mode_reg == LPMC_HALT) |-> (!rtc_clk_en && !cpu_clk_en && periph_clk_en == '0))
    else $error("halt clock gating wrong");
  AST_FAST_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE11
    (ref_wait_reg && fast_wake_en) |-> (rec_cyc_reg < LPMC_CNT_W'(FAST_WAKE_CYC)))
    else $error("fast wake too slow");
  AST_RUN_RESTORE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
    ($past(mode_reg) != LPMC_RUN && mode_reg == LPMC_RUN)
      |-> (cpu_clk_en && periph_clk_en == '1 && rtc_clk_en))
    else $error("clocks not restored in run");
endmodule // lpmc_ctrl
`default_nettype wire

// *** testbench/lpmc_cpu_model.sv ***
// Partner model: CPU-side interrupt masking in front of the controller
`timescale 1ns/100ps
`default_nettype none
module lpmc_cpu_model
  import lpmc_pkg::*;
(
  input  wire logic       irq_req,
  input  wire logic       unmask_lp,
  input  wire logic [5:0] mode_out,
  output var  logic       int_irq
);
  logic lp_active;
  always_comb begin
    lp_active = |(mode_out & (LPMC_LP_RUN | LPMC_LP_WAIT));
    // Software keeps interrupts masked in both low power modes unless told to misbehave
    int_irq   = irq_req & (unmask_lp | !lp_active);
  end
endmodule // lpmc_cpu_model
`default_nettype wire

// *** testbench/test_low_power_mode_controller.sv ***
// Self-checking testbench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
module test_low_power_mode_controller;
  import lpmc_pkg::*;
  // Shortened wakeup counts keep the halt scenarios brief
  localparam int REF_CYC  = 3;
  localparam int FAST_CYC = 2;
  localparam int P_EVI = 0, P_IRI = 1, P_HALT = 2, P_LPIN = 3, P_LPOUT = 4, P_IRQ = 5;
  localparam int P_IEV = 6, P_RTC = 7, P_XIRQ = 8, P_XEV = 9, P_HWP = 10;
  logic        sys_clk          = 1'b0;
  logic        rst_n            = 1'b0;
  logic [10:0] pv               = 11'h000;
  logic        halt_rtc_keep    = 1'b0;
  logic        slow_osc_sel_ext = 1'b0;
  logic        ref_off_in_halt  = 1'b0;
  logic        fast_wake_en     = 1'b0;
  logic        unmask_lp        = 1'b0;
  logic [7:0]  run_sel          = 8'h5A;
  logic        int_irq, cpu_clk_en, rtc_clk_en, flash_on, slow_clk_sel;
  logic        osc_int_en, osc_ext_en, reg_ulp, ref_on, wake_pulse;
  logic [7:0]  periph_clk_en;
  logic [5:0]  mode_out;
  int          n_fail   = 0;
  int          compares = 0;
  int          cycles   = 0;

  always #2 sys_clk = ~sys_clk;

  lpmc_cpu_model cpu (.irq_req(pv[P_IRQ]), .unmask_lp(unmask_lp), .mode_out(mode_out),
                      .int_irq(int_irq));

  lpmc_ctrl #(.NUM_PERIPH(8), .REF_WAKE_CYC(REF_CYC), .FAST_WAKE_CYC(FAST_CYC)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .wait_for_event_instr(pv[P_EVI]), .wait_for_interrupt_instr(pv[P_IRI]),
    .halt_req(pv[P_HALT]), .halt_rtc_keep(halt_rtc_keep),
    .lp_run_enter_req(pv[P_LPIN]), .lp_run_exit_req(pv[P_LPOUT]),
    .slow_osc_sel_ext(slow_osc_sel_ext), .ref_off_in_halt(ref_off_in_halt),
    .fast_wake_en(fast_wake_en), .periph_run_sel(run_sel), .int_irq(int_irq),
    .int_event(pv[P_IEV]), .rtc_irq(pv[P_RTC]), .ext_irq_pin(pv[P_XIRQ]),
    .ext_event_pin(pv[P_XEV]), .halt_wake_periph(pv[P_HWP]),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .rtc_clk_en(rtc_clk_en),
    .flash_on(flash_on), .slow_clk_sel(slow_clk_sel),
    .low_speed_internal_osc_en(osc_int_en), .low_speed_external_osc_en(osc_ext_en),
    .reg_ulp(reg_ulp), .ref_on(ref_on), .wake_pulse(wake_pulse), .mode_out(mode_out));

  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle request; returns just after the edge that sampled it
  task automatic pulse(input int idx);
    @(posedge sys_clk);
    pv[idx] <= 1'b1;
    @(posedge sys_clk);
    pv <= 11'h000;
    #1;
  endtask

  task automatic wait_mode(input logic [5:0] m, output int n);
    n = 0;
    while (mode_out !== m && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(mode_out, m);
  endtask

  task automatic t_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check({cpu_clk_en, rtc_clk_en, flash_on, ref_on, periph_clk_en}, 12'hFFF);
    check({slow_clk_sel, osc_int_en, osc_ext_en, reg_ulp, wake_pulse, mode_out},
          {5'h00, LPMC_RUN});
    @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic t_wait();
    int n;
    int src[4] = '{P_IRQ, P_IEV, P_XIRQ, P_XEV};
    for (int i = 0; i < 4; i++) begin
      pulse(i % 2);
      check(mode_out, LPMC_WAIT);
      check({cpu_clk_en, rtc_clk_en, periph_clk_en}, {2'b01, run_sel});
      pulse(src[i]);
      wait_mode(LPMC_RUN, n);
      check(16'(n), (i < 2) ? 16'h0000 : 16'h0002);
      check({cpu_clk_en, wake_pulse, periph_clk_en}, 10'h3FF);
    end
  endtask

  task automatic t_lp(input logic ext, input int src);
    int n;
    @(posedge sys_clk);
    slow_osc_sel_ext <= ext;
    pulse(P_LPIN);
    check(mode_out, LPMC_LP_RUN);
    check({cpu_clk_en, slow_clk_sel, flash_on, reg_ulp, osc_int_en, osc_ext_en},
          {4'b1101, !ext, ext});
    check(periph_clk_en, run_sel);
    // Interrupts left unmasked on purpose: they must still not end the mode
    @(posedge sys_clk);
    unmask_lp <= 1'b1;
    pulse(P_IRQ);
    pulse(P_IRI);
    pulse(P_HALT);
    check(mode_out, LPMC_LP_RUN);
    pulse(P_EVI);
    check({cpu_clk_en, flash_on, mode_out}, {2'b00, LPMC_LP_WAIT});
    pulse(P_IRQ);
    pulse(P_LPOUT);
    check(mode_out, LPMC_LP_WAIT);
    @(posedge sys_clk);
    unmask_lp <= 1'b0;
    pulse(src);
    wait_mode(LPMC_LP_RUN, n);
    check({cpu_clk_en, wake_pulse, flash_on}, 3'b110);
    pulse(P_LPOUT);
    check({flash_on, reg_ulp, mode_out}, {2'b10, LPMC_RUN});
  endtask

  task automatic t_halt();
    int n_ref;
    int n_fast;
    @(posedge sys_clk);
    halt_rtc_keep <= 1'b1;
    pulse(P_HALT);
    check(mode_out, LPMC_ACT_HALT);
    check({cpu_clk_en, rtc_clk_en, ref_on, periph_clk_en}, 11'h300);
    pulse(P_IRQ);
    pulse(P_HWP);
    pulse(P_IEV);
    check(mode_out, LPMC_ACT_HALT);
    pulse(P_RTC);
    wait_mode(LPMC_RUN, n_ref);
    check(16'(n_ref), 16'(FAST_CYC));
    check({cpu_clk_en, rtc_clk_en, periph_clk_en}, 10'h3FF);
    @(posedge sys_clk);
    halt_rtc_keep   <= 1'b0;
    ref_off_in_halt <= 1'b1;
    pulse(P_HALT);
    check({cpu_clk_en, rtc_clk_en, ref_on, periph_clk_en}, 11'h000);
    pulse(P_RTC);
    check(mode_out, LPMC_HALT);
    pulse(P_XIRQ);
    wait_mode(LPMC_RUN, n_ref);
    // Pin wake: two synchroniser cycles, then the full recovery count
    check(16'(n_ref), 16'(REF_CYC + 2));
    check({ref_on, wake_pulse}, 2'b11);
    @(posedge sys_clk);
    fast_wake_en <= 1'b1;
    pulse(P_HALT);
    pulse(P_HWP);
    wait_mode(LPMC_RUN, n_fast);
    // Pin wake pays two synchroniser cycles on top of the longer recovery
    check(16'(n_ref - n_fast), 16'(REF_CYC - FAST_CYC + 2));
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    t_reset();
    t_wait();
    t_lp(1'b0, P_IEV);
    t_lp(1'b1, P_XEV);
    t_halt();
    pulse(P_LPIN);
    pulse(P_EVI);
    t_reset();
    tally_and_finish();
  end
endmodule // test_low_power_mode_controller
`default_nettype wire
